// file: pkg/mdc_pkg.sv
// Package of constants, types and helpers for the microstep drive control
package mdc_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int CLK_HZ = 40_000_000;
  localparam int STEP_RATE_MAX_HZ = 3_000_000;
  // Least step period rounds up to whole cycles (14 at 40 MHz)
  localparam int MIN_STEP_CYCLES = (CLK_HZ + STEP_RATE_MAX_HZ - 1)
                                   / STEP_RATE_MAX_HZ;
  localparam int SAMPLE_US = 1000;
  localparam int SAMPLE_CYCLES = (CLK_HZ / 1_000_000) * SAMPLE_US;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_HOLD = 8'h04;
  localparam logic [7:0] OFS_RATE = 8'h08;
  localparam logic [7:0] OFS_CYCLEN = 8'h0C;
  localparam logic [7:0] OFS_ASTEP = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_FAULT = 8'h18;
  localparam logic [7:0] OFS_POS = 8'h1C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;

  // Reset values
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [14:0] HOLD_RST = 15'h0000;
  localparam logic [15:0] RATE_RST = 16'h0000;
  localparam logic [15:0] CYCLEN_RST = 16'h0000;
  localparam logic [23:0] ASTEP_RST = 24'h000000;

  // Field positions and widths
  localparam int HOLD_W = 15;
  localparam int IRQ_W = 3;
  localparam int IRQ_LOCKOUT = 0;
  localparam int IRQ_GAIN_REFUSED = 1;
  localparam int IRQ_CYCLEN_SHORT = 2;

  // ************************************************************
  // Drive figures
  // ************************************************************
  localparam int USTEP_PER_FULL = 256;
  localparam int USTEP_PER_CYCLE = 4 * USTEP_PER_FULL;
  localparam int IDX_W = 10;
  localparam logic [IDX_W-1:0] QUARTER_SHIFT = 10'h100;
  localparam int ROM_AW = 9;
  localparam int ROM_DEPTH = USTEP_PER_FULL + 1;
  localparam int ROM_DW = 15;
  localparam int ANG_W = 26;
  localparam logic [15:0] CYCLEN_MIN = 16'h0050;
  localparam logic [7:0] FAULT_LOCKOUT = 8'h03;
  // Peak phase currents in milliamps per gain code
  localparam logic [15:0] GAIN0_MA = 16'h02EE;
  localparam logic [15:0] GAIN1_MA = 16'h05DC;
  localparam logic [15:0] GAIN2_MA = 16'h0BB8;
  localparam logic [15:0] GAIN3_MA = 16'h1770;
  // Torque gain 0.8 A/V: mA = mV * 13107 / 2^14
  localparam logic signed [15:0] TQ_MUL = 16'sh3333;
  localparam int TQ_SHIFT = 14;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    MDC_MODE_STEPPER,
    MDC_MODE_SERVO3,
    MDC_MODE_SERVO2
  } mdc_mode_e;

  typedef struct packed {
    logic [1:0] gain;
    logic servo;
    logic dir;
    logic enable;
  } mdc_ctrl_s;

  typedef struct packed {
    logic signed [15:0] a;
    logic signed [15:0] b;
  } mdc_phase_s;

  // Peak current in mA for a gain code
  function automatic logic [15:0] mdc_gain_ma(input logic [1:0] code);
    unique case (code)
      2'h0: return GAIN0_MA;
      2'h1: return GAIN1_MA;
      2'h2: return GAIN2_MA;
      2'h3: return GAIN3_MA;
    endcase
  endfunction

endpackage

// file: rtl/mdc_sine_rom.sv
// Quarter-wave sine table with registered read data
`timescale 1ns/1ps
module mdc_sine_rom
  import mdc_pkg::*;
(
  input wire logic i_clock,               // System clock
  input wire logic [ROM_AW-1:0] i_addr,   // Quarter-wave index 0..256
  output logic [ROM_DW-1:0] o_data        // Sine magnitude, Q15
);

  logic [ROM_DW-1:0] rom [ROM_DEPTH];

  // Rational sine fit, good to a fraction of a percent
  function automatic logic [ROM_DW-1:0] sine_fit(input int q);
    longint p;
    longint v;
    p = longint'(q) * longint'(512 - q);
    v = (longint'(32767) * 16 * p) / (longint'(5) * 512 * 512 - 4 * p);
    return v[ROM_DW-1:0];
  endfunction

  // ************************************************************
  // Table contents, fixed at elaboration
  // ************************************************************
  initial begin
    for (int i = 0; i < ROM_DEPTH; i++) begin
      rom[i] = sine_fit(i);
    end
  end

  // Registered read
  always_ff @(posedge i_clock) begin
    o_data <= rom[i_addr];
  end

endmodule // mdc_sine_rom

// file: rtl/mdc_drive.sv
// Microstep and two-phase servo drive control with register port
// Overview of operation
// - Full step is 256 microsteps; electrical cycle is 1024 positions.
// - Step generator runs up to three million microsteps per second.
// - Gain code 0..3 selects peak 0.75, 1.5, 3 or 6 A.
// - Hold current applies only when reference position is unchanged.
// - Hold mode zero keeps full current whenever enabled in stepper mode.
// - Hold mode one cuts current to a quarter at rest.
// - Hold mode m waits m samples at rest, then quarter current.
// - Motor type resets to stepper; servo selects sinusoidal servo.
// - Two-phase servo needs option fitted and servo type, else three-phase.
// - Two-phase commands are 90 degrees apart electrically.
// - Two-phase mode is torque mode at 0.8 A per volt.
// - Lockout disables drive, fault query reads 3, lockout status bit set; o_irq only if its mask bit is set.
`timescale 1ns/1ps
module mdc_drive
  import mdc_pkg::*;
#(
  parameter int SAMPLE_TICKS = SAMPLE_CYCLES  // Servo sample period, cycles
)(
  input wire logic i_clock,                  // 40 MHz clock
  input wire logic i_nrst,                   // Async reset, active low
  input wire logic [ADDR_W-1:0] i_addr,      // Register address
  input wire logic [31:0] i_wdata,           // Write data
  input wire logic i_wr,                     // Write strobe
  input wire logic i_rd,                     // Read strobe
  output logic [31:0] o_rdata,               // Read data, cycle after i_rd
  input wire logic i_lockout,                // Lockout pin, active high
  input wire logic i_two_phase_opt,          // Two-phase option strap
  input wire logic i_enc_step,               // Encoder count pulse pin
  input wire logic i_enc_dir,                // Encoder direction pin
  input wire logic signed [15:0] i_torque_mv, // Torque command, mV
  output logic signed [15:0] o_phase_a,      // Phase A current, mA
  output logic signed [15:0] o_phase_b,      // Phase B current, mA
  output logic o_bridge_en,                  // Power bridge enable
  output logic [1:0] o_mode,                 // Active drive mode
  output logic o_irq                         // Amplifier error interrupt
);

  // ************************************************************
  // Reset release and pin synchronisers
  // ************************************************************
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [1:0] elo_sync_r;
  logic [1:0] estep_sync_r;
  logic [1:0] edir_sync_r;
  logic estep_prev_r;
  logic [1:0] opt_sync_r;

  // Release reset through two flops
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // Pins are asynchronous; only stage two is looked at
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      elo_sync_r <= 2'h0;
      estep_sync_r <= 2'h0;
      edir_sync_r <= 2'h0;
      estep_prev_r <= 1'b0;
      opt_sync_r <= 2'h0;
    end else begin
      elo_sync_r <= {elo_sync_r[0], i_lockout};
      estep_sync_r <= {estep_sync_r[0], i_enc_step};
      edir_sync_r <= {edir_sync_r[0], i_enc_dir};
      estep_prev_r <= estep_sync_r[1];
      opt_sync_r <= {opt_sync_r[0], i_two_phase_opt};
    end
  end

  logic enc_pulse;
  assign enc_pulse = estep_sync_r[1] & ~estep_prev_r;

  // Strap frozen three edges after release, once its synchroniser is full
  logic opt_r;
  logic [1:0] opt_wait_r;
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      opt_r <= 1'b0;
      opt_wait_r <= 2'h0;
    end else if (opt_wait_r != 2'h3) begin
      opt_r <= opt_sync_r[1];
      opt_wait_r <= opt_wait_r + 2'h1;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  mdc_ctrl_s ctrl_r;
  logic [HOLD_W-1:0] hold_r;
  logic [15:0] rate_r;
  logic [15:0] cyclen_r;
  logic [23:0] astep_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic locked_r;
  logic mo_seen_r;
  logic [31:0] ref_pos_r;
  logic reduced_r;
  logic moving_r;
  logic drive_on;
  logic two_phase;
  logic wr_ctrl;
  logic gain_refused;

  assign wr_ctrl = i_wr && (i_addr == OFS_CTRL);
  assign drive_on = ctrl_r.enable && !locked_r;
  assign two_phase = ctrl_r.servo && opt_r;
  assign gain_refused = wr_ctrl && ctrl_r.enable
                        && (i_wdata[4:3] != ctrl_r.gain);

  // Control register; motor type resets to stepper
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= mdc_ctrl_s'(CTRL_RST);
    end else if (wr_ctrl) begin
      ctrl_r.enable <= i_wdata[0];
      ctrl_r.dir <= i_wdata[1];
      ctrl_r.servo <= i_wdata[2];
      if (!ctrl_r.enable) begin
        ctrl_r.gain <= i_wdata[4:3];
      end
    end
  end

  // Plain configuration registers
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      hold_r <= HOLD_RST;
      rate_r <= RATE_RST;
      cyclen_r <= CYCLEN_RST;
      astep_r <= ASTEP_RST;
      irq_mask_r <= '0;
    end else if (i_wr) begin
      if (i_addr == OFS_HOLD) hold_r <= i_wdata[HOLD_W-1:0];
      if (i_addr == OFS_RATE) rate_r <= i_wdata[15:0];
      if (i_addr == OFS_CYCLEN) cyclen_r <= i_wdata[15:0];
      if (i_addr == OFS_ASTEP) astep_r <= i_wdata[23:0];
      if (i_addr == OFS_IRQ_MASK) irq_mask_r <= i_wdata[IRQ_W-1:0];
    end
  end

  // ************************************************************
  // Lockout
  // ************************************************************
  // latch lockout
  // Held while the pin is high; cleared by disable then enable
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      locked_r <= 1'b0;
      mo_seen_r <= 1'b0;
    end else if (elo_sync_r[1]) begin
      locked_r <= 1'b1;
      mo_seen_r <= 1'b0;
    end else if (locked_r && wr_ctrl) begin
      if (!i_wdata[0]) begin
        mo_seen_r <= 1'b1;
      end else if (mo_seen_r) begin
        locked_r <= 1'b0;
        mo_seen_r <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Interrupts
  // ************************************************************
  logic [IRQ_W-1:0] irq_ev;
  logic [IRQ_W-1:0] irq_clr;
  logic locked_prev_r;
  logic cyclen_short;

  assign cyclen_short = two_phase && drive_on && (cyclen_r < CYCLEN_MIN);
  logic cyclen_short_r;

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      locked_prev_r <= 1'b0;
      cyclen_short_r <= 1'b0;
    end else begin
      locked_prev_r <= locked_r;
      cyclen_short_r <= cyclen_short;
    end
  end

  assign irq_ev[IRQ_LOCKOUT] = locked_r && !locked_prev_r;
  assign irq_ev[IRQ_GAIN_REFUSED] = gain_refused;
  assign irq_ev[IRQ_CYCLEN_SHORT] = cyclen_short && !cyclen_short_r;
  assign irq_clr = (i_wr && (i_addr == OFS_IRQ_STAT)) ?
                   i_wdata[IRQ_W-1:0] : '0;

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_r <= '0;
      o_irq <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
      o_irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ************************************************************
  // Step generator and sample tick
  // ************************************************************
  logic [15:0] step_cnt_r;
  logic [15:0] step_period;
  logic step_go;
  logic [IDX_W-1:0] ustep_idx_r;
  logic [31:0] tick_cnt_r;
  logic tick;

  // rate ceiling
  // Slower than asked is safer than exceeding the bridge rate
  assign step_period = (rate_r < 16'(MIN_STEP_CYCLES)) ?
                       16'(MIN_STEP_CYCLES) : rate_r;
  assign step_go = drive_on && !ctrl_r.servo && (rate_r != 16'h0000)
                   && (step_cnt_r >= step_period - 16'h0001);

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      step_cnt_r <= 16'h0000;
    end else if (step_go || !drive_on || rate_r == 16'h0000) begin
      step_cnt_r <= 16'h0000;
    end else begin
      step_cnt_r <= step_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      ustep_idx_r <= '0;
      ref_pos_r <= 32'h00000000;
    end else if (step_go) begin
      ustep_idx_r <= ctrl_r.dir ? ustep_idx_r - IDX_W'(1)
                                : ustep_idx_r + IDX_W'(1);
      ref_pos_r <= ctrl_r.dir ? ref_pos_r - 32'h1 : ref_pos_r + 32'h1;
    end
  end

  // Servo sample divider
  assign tick = (tick_cnt_r == 32'(SAMPLE_TICKS - 1));
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= 32'h00000000;
    end else begin
      tick_cnt_r <= tick ? 32'h00000000 : tick_cnt_r + 32'h1;
    end
  end

  // ************************************************************
  // Hold current
  // ************************************************************
  logic [31:0] pos_prev_r;
  logic [HOLD_W-1:0] rest_cnt_r;
  logic at_rest;

  assign at_rest = (ref_pos_r == pos_prev_r);

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      pos_prev_r <= 32'h00000000;
      rest_cnt_r <= '0;
      reduced_r <= 1'b0;
      moving_r <= 1'b0;
    end else if (tick) begin
      pos_prev_r <= ref_pos_r;
      moving_r <= !at_rest;
      if (!at_rest || hold_r == '0) begin
        rest_cnt_r <= '0;
        reduced_r <= 1'b0;
      end else if (hold_r == HOLD_W'(1)) begin
        reduced_r <= 1'b1;
      end else if (rest_cnt_r >= hold_r - HOLD_W'(1)) begin
        reduced_r <= 1'b1;
      end else begin
        rest_cnt_r <= rest_cnt_r + HOLD_W'(1);
      end
    end
  end

  // ************************************************************
  // Commutation angle and amplitude
  // ************************************************************
  logic [ANG_W-1:0] angle_r;
  logic [IDX_W-1:0] idx;
  logic signed [15:0] amp;
  logic signed [31:0] torque_prod;
  logic [15:0] full_ma;

  // Encoder counts walk the electrical angle
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      angle_r <= '0;
    end else if (enc_pulse) begin
      angle_r <= edir_sync_r[1] ? angle_r - ANG_W'(astep_r)
                                : angle_r + ANG_W'(astep_r);
    end
  end

  assign idx = two_phase ? angle_r[ANG_W-1 -: IDX_W] : ustep_idx_r;
  assign full_ma = mdc_gain_ma(ctrl_r.gain);
  assign torque_prod = 32'(i_torque_mv) * 32'(TQ_MUL);

  always_comb begin
    if (!drive_on || (ctrl_r.servo && !two_phase)) begin
      amp = 16'sh0000;
    end else if (two_phase) begin
      amp = torque_prod[TQ_SHIFT +: 16];
    end else if (reduced_r && hold_r != '0) begin
      amp = $signed({2'h0, full_ma[15:2]});
    end else begin
      amp = $signed(full_ma);
    end
  end

  // ************************************************************
  // Sine lookup, phases A and B alternate on one table port
  // ************************************************************
  logic sel_r;
  logic sel_d_r;
  logic neg_d_r;
  logic [IDX_W-1:0] ph_idx;
  logic [ROM_AW-1:0] rom_addr;
  logic [ROM_DW-1:0] rom_data;
  logic signed [31:0] prod;
  mdc_phase_s phase_r;

  // B leads by a quarter cycle
  assign ph_idx = sel_r ? idx + QUARTER_SHIFT : idx;
  assign rom_addr = ph_idx[8] ? ROM_AW'(9'h100 - {1'b0, ph_idx[7:0]})
                              : {1'b0, ph_idx[7:0]};

  mdc_sine_rom u_rom (
    .i_clock (i_clock),
    .i_addr (rom_addr),
    .o_data (rom_data)
  );

  assign prod = 32'($signed({1'b0, rom_data})) * 32'(amp);

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      sel_r <= 1'b0;
      sel_d_r <= 1'b0;
      neg_d_r <= 1'b0;
      phase_r <= '0;
    end else begin
      sel_r <= ~sel_r;
      sel_d_r <= sel_r;
      neg_d_r <= ph_idx[9];
      if (sel_d_r) begin
        phase_r.b <= neg_d_r ? -prod[30:15] : prod[30:15];
      end else begin
        phase_r.a <= neg_d_r ? -prod[30:15] : prod[30:15];
      end
    end
  end

  // ************************************************************
  // Outputs and read port
  // ************************************************************
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_phase_a <= 16'sh0000;
      o_phase_b <= 16'sh0000;
      o_bridge_en <= 1'b0;
      o_mode <= 2'h0;
    end else begin
      o_phase_a <= phase_r.a;
      o_phase_b <= phase_r.b;
      o_bridge_en <= drive_on;
      o_mode <= !ctrl_r.servo ? MDC_MODE_STEPPER
              : (two_phase ? MDC_MODE_SERVO2 : MDC_MODE_SERVO3);
    end
  end

  // Unmapped addresses read zero
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= 32'h00000000;
    end else if (!i_rd) begin
      o_rdata <= 32'h00000000;
    end else begin
      unique case (i_addr)
        OFS_CTRL: o_rdata <= 32'(ctrl_r);
        OFS_HOLD: o_rdata <= 32'(hold_r);
        OFS_RATE: o_rdata <= 32'(rate_r);
        OFS_CYCLEN: o_rdata <= 32'(cyclen_r);
        OFS_ASTEP: o_rdata <= 32'(astep_r);
        OFS_STATUS: o_rdata <= 32'({two_phase, moving_r,
                                    reduced_r, drive_on});
        OFS_FAULT: o_rdata <= locked_r ? 32'(FAULT_LOCKOUT) : 32'h0;
        OFS_POS: o_rdata <= ref_pos_r;
        OFS_IRQ_STAT: o_rdata <= 32'(irq_stat_r);
        OFS_IRQ_MASK: o_rdata <= 32'(irq_mask_r);
        default: o_rdata <= 32'h00000000;
      endcase
    end
  end

endmodule // mdc_drive

// file: testbench/mdc_drive_chk.sv
// Port checker for the microstep drive control
`timescale 1ns/1ps
module mdc_drive_chk
  import mdc_pkg::*;
#(
  parameter int SAMPLE_TICKS = SAMPLE_CYCLES // Sample period, cycles
)(
  input wire logic i_clock, // Clock
  input wire logic i_nrst, // Reset, active low
  input wire logic [ADDR_W-1:0] i_addr, // Address
  input wire logic [31:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  input wire logic [31:0] o_rdata, // Read data
  input wire logic i_lockout, // Lockout pin
  input wire logic i_two_phase_opt, // Option strap
  input wire logic i_enc_step, // Encoder count
  input wire logic i_enc_dir, // Encoder direction
  input wire logic signed [15:0] i_torque_mv, // Torque command
  input wire logic signed [15:0] o_phase_a, // Phase A
  input wire logic signed [15:0] o_phase_b, // Phase B
  input wire logic o_bridge_en, // Bridge enable
  input wire logic [1:0] o_mode, // Drive mode
  input wire logic o_irq // Interrupt
);
  // One clock domain, reset masks everything
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  chk_rd_pulse: assert property (
    o_rdata != 32'h0 |-> $past(i_rd))
    else $error("read data without a read");
  chk_lock_off: assert property (
    i_lockout [*5] |-> !o_bridge_en)
    else $error("bridge on while locked out");
  chk_strap_mode: assert property (
    o_mode == 2'h2 |-> i_two_phase_opt)
    else $error("two-phase mode without option");
  chk_step_peak: assert property (
    o_mode == 2'h0 |-> o_phase_a <= 16'sh1770 && o_phase_a >= -16'sh1770)
    else $error("stepper current above peak");
  chk_servo3_zero: assert property (
    (o_mode == 2'h1) [*6] |-> o_phase_a == 16'sh0 && o_phase_b == 16'sh0)
    else $error("phase drive in three-phase mode");
  chk_mode_cause: assert property (
    $changed(o_mode) |-> $past(i_wr) || $past(i_wr, 2) || $past(i_wr, 3))
    else $error("mode changed without a write");
  chk_bridge_on: assert property (
    $rose(o_bridge_en) |-> $past(i_wr, 2) || $past(i_wr, 3))
    else $error("bridge enabled without command");
  chk_irq_cause: assert property (
    $rose(o_irq) |-> $past(i_wr) || $past(i_wr, 2) || $past(i_wr, 3)
      || $past(i_lockout, 2))
    else $error("interrupt without cause");
endmodule // mdc_drive_chk

bind mdc_drive mdc_drive_chk #(.SAMPLE_TICKS(SAMPLE_TICKS)) u_chk (
  .i_clock, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
  .i_lockout, .i_two_phase_opt, .i_enc_step, .i_enc_dir, .i_torque_mv,
  .o_phase_a, .o_phase_b, .o_bridge_en, .o_mode, .o_irq);

// file: testbench/mdc_motor_model.sv
// Bridge and motor model giving motor-mounted encoder feedback
`timescale 1ns/1ps
module mdc_motor_model (
  input wire logic i_clock, // Clock
  input wire logic i_bridge_en, // Bridge enable from drive
  input wire logic i_go, // Start a move, one cycle
  input wire logic [7:0] i_counts, // Encoder counts to make
  input wire logic i_dir, // 1 = count down
  output logic o_enc_step = 1'b0, // Encoder count pin
  output logic o_enc_dir = 1'b0 // Encoder direction pin
);
  logic [7:0] left_r = 8'h00;
  logic [2:0] div_r = 3'h0;
  // encoder feedback
  // Rotor only turns while the bridge is powered
  always_ff @(posedge i_clock) begin
    if (i_go) begin
      left_r <= i_counts;
      o_enc_dir <= i_dir;
    end else if (left_r != 8'h00 && i_bridge_en) begin
      div_r <= div_r + 3'h1;
      o_enc_step <= div_r[2];
      if (div_r == 3'h7) left_r <= left_r - 8'h01;
    end else begin
      o_enc_step <= 1'b0;
    end
  end
endmodule // mdc_motor_model

// file: testbench/mdc_drive_test.sv
// Self-checking bench for the microstep drive control
`timescale 1ns/1ps
module mdc_drive_test;
  import mdc_pkg::*;
  localparam int ST = 20; // Short sample period keeps runs brief
  logic i_clock = 1'b0, i_nrst = 1'b0, wr = 1'b0, rd = 1'b0;
  logic lock = 1'b0, opt = 1'b0, go = 1'b0, mdir = 1'b0;
  logic estep, edir, ben, irq;
  logic [7:0] addr = 8'h00, cnt = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, p0, p1;
  logic signed [15:0] torque = 16'sh0, pa, pb;
  logic [1:0] mode;
  logic [15:0] seed = 16'hE3DD;
  int mismatches = 0, check_count = 0, r, h, dd, t;
  logic i0;

  mdc_drive #(.SAMPLE_TICKS(ST)) DUT (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_lockout(lock), .i_two_phase_opt(opt), .i_enc_step(estep),
    .i_enc_dir(edir), .i_torque_mv(torque), .o_phase_a(pa),
    .o_phase_b(pb), .o_bridge_en(ben), .o_mode(mode), .o_irq(irq));
  mdc_motor_model u_motor (.i_clock(i_clock), .i_bridge_en(ben),
    .i_go(go), .i_counts(cnt), .i_dir(mdir), .o_enc_step(estep),
    .o_enc_dir(edir));

  // Free-running 40 MHz clock
  initial forever #12.5 i_clock = ~i_clock;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Sine fit is approximate, so compare within a band
  function automatic logic near(input logic signed [15:0] s, input int e);
    int d;
    // An unknown must never slip through the int conversion
    if ($isunknown(s)) return 1'b0;
    d = int'(s) - e;
    if (d < 0) d = -d;
    return d <= (e < 0 ? -e : e) / 64 + 8;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge i_clock);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge i_clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    logic [31:0] d;
    rreg(a, d);
    chk(d & m, e);
  endtask
  task automatic do_reset(input logic strap);
    i_nrst <= 1'b0;
    opt <= strap;
    tick(16);
    i_nrst <= 1'b1;
    tick(3);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    tick(20000);
    mismatches++;
    test_done;
  end

  // Main sequence
  initial begin
    do_reset(1'b0);
    chk(mode, 32'h0);
    rchk(OFS_CTRL, 32'hFF, 32'h0);
    rchk(8'h3C, 32'hFFFFFFFF, 32'h0);
    for (int g = 0; g < 4; g++) begin
      // Disable first with the old gain, so no change is refused
      wreg(OFS_CTRL, 32'(g == 0 ? 0 : g - 1) << 3);
      wreg(OFS_CTRL, (32'(g) << 3) | 32'h1);
      tick(12);
      chk(near(pb, 750 << g), 1'b1);
      chk(near(pa, 0), 1'b1);
    end
    tick(3 * ST);
    chk(near(pb, 6000), 1'b1);
    // Gain change while enabled breaks the host rule on purpose
    wreg(OFS_CTRL, 32'h1);
    rchk(OFS_CTRL, 32'h18, 32'h18);
    rchk(OFS_IRQ_STAT, 32'h2, 32'h2);
    wreg(OFS_IRQ_STAT, 32'h2);
    rchk(OFS_IRQ_STAT, 32'h7, 32'h0);
    for (int k = 0; k < 2; k++) begin
      r = (k == 0) ? 1 : 1 + int'(seed % 16'd40);
      seed = lfsr(seed);
      rreg(OFS_POS, p0);
      wreg(OFS_CTRL, 32'h19 | (32'(k) << 1));
      wreg(OFS_RATE, 32'(r));
      tick((r < 14 ? 14 : r) * 40);
      wreg(OFS_RATE, 32'h0);
      rreg(OFS_POS, p1);
      dd = int'(p1 - p0) - (k == 1 ? -40 : 40);
      chk(32'((dd & 1023) <= 2 || (dd & 1023) >= 1022), 32'h1);
      // Forty steps from index 0, then forty back to it
      chk(near(pa, k ? 0 : 1458), 1'b1);
    end
    for (int k = 0; k < 3; k++) begin
      h = (k == 2) ? 4 : k;
      wreg(OFS_HOLD, 32'(h));
      wreg(OFS_RATE, 32'h1);
      tick(3 * ST);
      rchk(OFS_STATUS, 32'h2, 32'h0);
      wreg(OFS_RATE, 32'h0);
      tick(2 * ST);
      rchk(OFS_STATUS, 32'h2, (h == 1) ? 32'h2 : 32'h0);
      tick(4 * ST);
      rchk(OFS_STATUS, 32'h2, (h != 0) ? 32'h2 : 32'h0);
    end
    wreg(OFS_IRQ_MASK, 32'h0);
    lock <= 1'b1;
    tick(8);
    chk(ben, 1'b0);
    rchk(OFS_FAULT, 32'hFF, 32'h3);
    rchk(OFS_IRQ_STAT, 32'h1, 32'h1);
    i0 = irq;
    chk(i0, 1'b0);
    wreg(OFS_IRQ_MASK, 32'h7);
    tick(2);
    chk(irq, 1'b1);
    lock <= 1'b0;
    tick(4);
    // Recovery: disable then enable again
    wreg(OFS_CTRL, 32'h18);
    wreg(OFS_CTRL, 32'h19);
    tick(3);
    chk(ben, 1'b1);
    wreg(OFS_IRQ_STAT, 32'h7);
    tick(2);
    rchk(OFS_IRQ_STAT, 32'h7, 32'h0);
    wreg(OFS_CTRL, 32'h1D);
    tick(8);
    chk(mode, 32'h1);
    chk({pa, pb}, 32'h0);
    do_reset(1'b1);
    t = int'(seed % 16'd4000) - 2000;
    torque <= 16'(t);
    // 128 counts per electrical cycle, so the step is 2^26 / 128
    wreg(OFS_CYCLEN, 32'h80);
    wreg(OFS_ASTEP, 32'h80000);
    wreg(OFS_CTRL, 32'h5);
    tick(12);
    chk(mode, 32'h2);
    chk(near(pb, t * 4 / 5), 1'b1);
    chk(near(pa, 0), 1'b1);
    // Quarter cycle forward, then the same distance back
    for (int k = 0; k < 2; k++) begin
      cnt <= 8'h20;
      mdir <= k[0];
      go <= 1'b1;
      tick(1);
      go <= 1'b0;
      tick(300);
      chk(near(pa, k ? 0 : t * 4 / 5), 1'b1);
      chk(near(pb, k ? t * 4 / 5 : 0), 1'b1);
    end
    wreg(OFS_CYCLEN, 32'h28);
    rchk(OFS_IRQ_STAT, 32'h4, 32'h4);
    test_done;
  end
endmodule // mdc_drive_test
